//--- cbi_device.sv
// How it works
// - drive register picks each output standard
// - one enable bit per output
// - disabled output holds logic zero
// - single-ended pair: both pins toggle, shared settings
// - bit picks complement in phase or inverted
// - four stored configuration banks
// - loaded registers writable after reset
// - writes lost; reset reloads stored bank
// - power-on reset lasts at most ten ms
// - leaving reset copies bank into registers
// - no answer or clocks before load completes
// - slave answers one of two addresses
// - byte block writes and reads
// - master sends two pointer bytes first
// - ascending registers, msb first
// - transfer may stop after any byte
// - block write commits together at stop
// - master clocks SCL within 10-400 kHz
// - save bit burns bank, restore bit reloads
// - no acknowledge while save or restore runs
// - address select bit moves address to alternate
`timescale 1ns/1ps
module cbi_device #(
	parameter int unsigned POR_CYCLES = cbi_pkg::POR_CYCLES
) (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	// serial link
	cbi_link_if.dev         link,
	// bank select straps and reference clock
	input  wire logic [1:0] cfg_select,
	input  wire logic       src_clk,
	// clock outputs, drive type and load status
	output logic      [1:0] clock_out_true,
	output logic      [1:0] clock_out_complement,
	output logic      [3:0] drive_type,
	output logic            config_ready
);
	localparam int AW = $clog2(cbi_pkg::NREG);

	typedef struct packed {
		logic [2:0]                       scl_sy;
		logic [2:0]                       sda_sy;
		logic [1:0]                       src_sy;
		logic [1:0]                       sel_m;
		logic [1:0]                       sel_s;
		logic [21:0]                      por_cnt;
		logic                             por_done;
		logic [1:0]                       bank;
		logic [7:0]                       nvm_cnt;
		logic                             op_burn;
		logic                             ready;
		cbi_pkg::cbi_dst_t                st;
		logic [3:0]                       bcnt;
		logic [7:0]                       sh;
		logic [1:0]                       idx;
		logic                             rw;
		logic                             ack;
		logic                             mack;
		logic [15:0]                      ptr;
		logic [cbi_pkg::NREG-1:0][7:0]    regs;
		logic [cbi_pkg::NREG-1:0][7:0]    wbuf;
		logic [cbi_pkg::NREG-1:0]         wmask;
		logic [7:0]                       cmd_pend;
		logic                             cmd_v;
		logic [7:0]                       cmd;
		logic                             sda_oe;
		logic                             sda_o;
		logic [1:0]                       out_t;
		logic [1:0]                       out_c;
		logic [3:0]                       drive;
	} cbi_dev_state_t;

	cbi_dev_state_t q;
	cbi_dev_state_t next_q;

	// stored banks survive reset_n, so they sit outside the reset state
	logic [3:0][cbi_pkg::NREG-1:0][7:0] otp = cbi_pkg::OTP_FACTORY;

	logic       scl_rise;
	logic       scl_fall;
	logic       start_seen;
	logic       stop_seen;
	logic       sda_in;
	logic       busy;
	logic [6:0] my_addr;
	logic [7:0] rd_byte;
	logic [7:0] nvm_req;

	assign scl_rise   = q.scl_sy[1] & ~q.scl_sy[2];
	assign scl_fall   = ~q.scl_sy[1] & q.scl_sy[2];
	assign start_seen = q.scl_sy[1] & q.scl_sy[2] & ~q.sda_sy[1] & q.sda_sy[2];
	assign stop_seen  = q.scl_sy[1] & q.scl_sy[2] & q.sda_sy[1] & ~q.sda_sy[2];
	assign sda_in     = q.sda_sy[1];
	assign busy       = q.nvm_cnt != 8'h00;
	assign my_addr    = q.regs[cbi_pkg::REG_ADDR_SEL[AW-1:0]][cbi_pkg::ADDR_SEL_BIT] ?
		cbi_pkg::DEV_ADDR_ALT : cbi_pkg::DEV_ADDR_DEFAULT;

	always_comb begin
		if (q.ptr < 16'(cbi_pkg::NREG))
			rd_byte = q.regs[q.ptr[AW-1:0]];
		else if (q.ptr == cbi_pkg::REG_NVM_CMD)
			rd_byte = {busy, q.cmd[6:0]};
		else
			rd_byte = 8'h00;
	end

	// one command byte straight after the address also counts as a command
	always_comb begin
		if (q.cmd_v)
			nvm_req = q.cmd_pend;
		else if (!q.rw && q.idx == 2'h2)
			nvm_req = q.ptr[15:8];
		else
			nvm_req = 8'h00;
	end

	always_ff @(posedge ref_clk) begin
		if (q.nvm_cnt == 8'h01 && q.op_burn)
			otp[q.bank] <= q.regs;
	end

	always_comb begin
		next_q        = q;
		next_q.scl_sy = {q.scl_sy[1:0], link.scl};
		next_q.sda_sy = {q.sda_sy[1:0], link.sda};
		next_q.src_sy = {q.src_sy[0], src_clk};
		next_q.sel_m  = cfg_select;
		next_q.sel_s  = q.sel_m;

		if (!q.por_done) begin
			if (q.por_cnt == 22'(POR_CYCLES - 1)) begin
				next_q.por_done = 1'b1;
				next_q.bank     = q.sel_s;
				next_q.op_burn  = 1'b0;
				next_q.nvm_cnt  = 8'(cbi_pkg::NVM_CYCLES);
			end else begin
				next_q.por_cnt = q.por_cnt + 22'h000001;
			end
		end

		if (busy) begin
			next_q.nvm_cnt = q.nvm_cnt - 8'h01;
			if (q.nvm_cnt == 8'h01) begin
				if (!q.op_burn) begin
					next_q.regs  = otp[q.bank];
					next_q.ready = 1'b1;
				end
				next_q.cmd = 8'h00;
			end
		end

		if (start_seen) begin
			next_q.st     = cbi_pkg::D_RX;
			next_q.bcnt   = 4'h0;
			next_q.idx    = 2'h0;
			next_q.sda_oe = 1'b0;
		end else if (stop_seen) begin
			next_q.st     = cbi_pkg::D_IDLE;
			next_q.sda_oe = 1'b0;
			next_q.idx    = 2'h0;
			next_q.cmd_v  = 1'b0;
			next_q.wmask  = '0;
			for (int i = 0; i < cbi_pkg::NREG; i++) begin
				if (q.wmask[i])
					next_q.regs[i] = q.wbuf[i];
			end
			if (q.ready && !busy) begin
				if (nvm_req[cbi_pkg::BURN_BIT]) begin
					next_q.op_burn = 1'b1;
					next_q.nvm_cnt = 8'(cbi_pkg::NVM_CYCLES);
					next_q.cmd     = nvm_req;
				end else if (nvm_req[cbi_pkg::RESTORE_BIT]) begin
					next_q.op_burn = 1'b0;
					next_q.nvm_cnt = 8'(cbi_pkg::NVM_CYCLES);
					next_q.cmd     = nvm_req;
				end
			end
		end else begin
			unique case (q.st)
				cbi_pkg::D_IDLE: begin
				end
				cbi_pkg::D_RX: begin
					if (scl_rise && q.bcnt < 4'h8) begin
						next_q.sh   = {q.sh[6:0], sda_in};
						next_q.bcnt = q.bcnt + 4'h1;
					end else if (scl_fall && q.bcnt == 4'h8) begin
						next_q.ack = 1'b1;
						unique case (q.idx)
							2'h0: begin
								// no answer before load or during save/restore
								next_q.ack = q.ready && !busy && q.sh[7:1] == my_addr;
								next_q.rw  = q.sh[0];
							end
							2'h1: next_q.ptr[15:8] = q.sh;
							2'h2: next_q.ptr[7:0] = q.sh;
							2'h3: begin
								if (q.ptr < 16'(cbi_pkg::NREG)) begin
									next_q.wbuf[q.ptr[AW-1:0]]  = q.sh;
									next_q.wmask[q.ptr[AW-1:0]] = 1'b1;
								end else if (q.ptr == cbi_pkg::REG_NVM_CMD) begin
									next_q.cmd_pend = q.sh;
									next_q.cmd_v    = 1'b1;
								end
								next_q.ptr = q.ptr + 16'h0001;
							end
						endcase
						if (next_q.ack && q.idx != 2'h3)
							next_q.idx = q.idx + 2'h1;
						next_q.st     = cbi_pkg::D_ACK;
						next_q.sda_oe = next_q.ack;
					end
				end
				cbi_pkg::D_ACK: begin
					if (scl_fall) begin
						if (!q.ack) begin
							next_q.st     = cbi_pkg::D_IDLE;
							next_q.sda_oe = 1'b0;
						end else if (q.rw) begin
							next_q.st     = cbi_pkg::D_TX;
							next_q.sh     = {rd_byte[6:0], 1'b0};
							next_q.sda_oe = ~rd_byte[7];
							next_q.bcnt   = 4'h1;
							next_q.ptr    = q.ptr + 16'h0001;
						end else begin
							next_q.st     = cbi_pkg::D_RX;
							next_q.bcnt   = 4'h0;
							next_q.sda_oe = 1'b0;
						end
					end
				end
				cbi_pkg::D_TX: begin
					if (scl_fall) begin
						if (q.bcnt == 4'h8) begin
							next_q.st     = cbi_pkg::D_MACK;
							next_q.sda_oe = 1'b0;
						end else begin
							next_q.sda_oe = ~q.sh[7];
							next_q.sh     = {q.sh[6:0], 1'b0};
							next_q.bcnt   = q.bcnt + 4'h1;
						end
					end
				end
				cbi_pkg::D_MACK: begin
					if (scl_rise)
						next_q.mack = ~sda_in;
					else if (scl_fall) begin
						if (q.mack) begin
							next_q.st     = cbi_pkg::D_TX;
							next_q.sh     = {rd_byte[6:0], 1'b0};
							next_q.sda_oe = ~rd_byte[7];
							next_q.bcnt   = 4'h1;
							next_q.ptr    = q.ptr + 16'h0001;
						end else begin
							next_q.st = cbi_pkg::D_IDLE;
						end
					end
				end
				default: next_q.st = cbi_pkg::D_IDLE;
			endcase
		end

		for (int i = 0; i < 2; i++) begin
			// outputs stay low until the first load is complete
			if (q.ready && q.regs[cbi_pkg::REG_OUT_EN[AW-1:0]][i]) begin
				next_q.out_t[i] = q.src_sy[1];
				if (q.regs[cbi_pkg::REG_PAIR[AW-1:0]][cbi_pkg::PAIR_SE_LSB + i])
					next_q.out_c[i] = q.src_sy[1] ^
						q.regs[cbi_pkg::REG_PAIR[AW-1:0]][cbi_pkg::PAIR_INV_LSB + i];
				else
					next_q.out_c[i] = ~q.src_sy[1];
			end else begin
				next_q.out_t[i] = 1'b0;
				next_q.out_c[i] = 1'b0;
			end
		end
		next_q.drive = q.regs[cbi_pkg::REG_DRIVE[AW-1:0]][3:0];
		next_q.sda_o = 1'b0;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			q    <= '0;
			q.st <= cbi_pkg::D_IDLE;
		end else begin
			q <= next_q;
		end
	end

	assign link.sda_dev_o     = q.sda_o;
	assign link.sda_dev_oe    = q.sda_oe;
	assign clock_out_true       = q.out_t;
	assign clock_out_complement = q.out_c;
	assign drive_type           = q.drive;
	assign config_ready         = q.ready;
endmodule : cbi_device

//--- cbi_host.sv
`timescale 1ns/1ps
module cbi_host (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	// serial link
	cbi_link_if.host        link,
	// register port
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata
);
	typedef struct packed {
		logic [1:0]          sda_sy;
		logic [9:0]          qcnt;
		logic [1:0]          ph;
		cbi_pkg::cbi_hst_t   st;
		logic [3:0]          bitn;
		logic [7:0]          sh;
		logic [1:0]          seq;
		logic                rdp;
		logic [3:0]          nb;
		logic                ackbit;
		logic [6:0]          dev;
		logic [15:0]         ptr;
		logic [3:0]          len;
		logic                rd_op;
		logic                busy;
		logic                nack;
		logic [7:0][7:0]     buffer;
		logic [7:0]          rdata;
		logic                scl_oe;
		logic                sda_oe;
	} cbi_host_state_t;

	cbi_host_state_t q;
	cbi_host_state_t next_q;
	logic            tick;
	logic            more_rx;

	assign tick    = q.qcnt == 10'(cbi_pkg::SCL_QUARTER_CYCLES - 1);
	assign more_rx = (q.nb + 4'h1) < q.len;

	always_comb begin
		next_q        = q;
		next_q.sda_sy = {q.sda_sy[0], link.sda};
		next_q.qcnt   = (q.st == cbi_pkg::H_IDLE || tick) ? 10'h000 : q.qcnt + 10'h001;
		next_q.rdata  = 8'h00;

		if (rd) begin
			if (addr[3])
				next_q.rdata = q.buffer[addr[2:0]];
			else if (addr == cbi_pkg::HREG_STAT)
				next_q.rdata = {6'h00, q.nack, q.busy};
			else if (addr == cbi_pkg::HREG_DEV)
				next_q.rdata = {1'b0, q.dev};
			else if (addr == cbi_pkg::HREG_LEN)
				next_q.rdata = {4'h0, q.len};
		end
		if (wr) begin
			if (addr[3])
				next_q.buffer[addr[2:0]] = wdata;
			else if (addr == cbi_pkg::HREG_DEV)
				next_q.dev = wdata[6:0];
			else if (addr == cbi_pkg::HREG_PTRH)
				next_q.ptr[15:8] = wdata;
			else if (addr == cbi_pkg::HREG_PTRL)
				next_q.ptr[7:0] = wdata;
			else if (addr == cbi_pkg::HREG_LEN)
				next_q.len = wdata[3:0];
			else if (addr == cbi_pkg::HREG_CTRL && wdata[cbi_pkg::CTRL_START] && !q.busy) begin
				next_q.rd_op = wdata[cbi_pkg::CTRL_READ];
				next_q.busy  = 1'b1;
				next_q.nack  = 1'b0;
				next_q.st    = cbi_pkg::H_START;
				next_q.ph    = 2'h0;
				next_q.seq   = 2'h0;
				next_q.rdp   = 1'b0;
				next_q.nb    = 4'h0;
			end
		end

		if (tick) begin
			next_q.ph = q.ph + 2'h1;
			unique case (q.st)
				cbi_pkg::H_IDLE: begin
				end
				cbi_pkg::H_START: begin
					unique case (q.ph)
						2'h0: next_q.sda_oe = 1'b0;
						2'h1: next_q.scl_oe = 1'b0;
						2'h2: next_q.sda_oe = 1'b1;
						2'h3: begin
							next_q.scl_oe = 1'b1;
							next_q.st     = cbi_pkg::H_TXB;
							next_q.bitn   = 4'h0;
							next_q.sh     = {q.dev, q.rdp};
						end
					endcase
				end
				cbi_pkg::H_TXB, cbi_pkg::H_RXB: begin
					unique case (q.ph)
						2'h0: begin
							if (q.bitn == 4'h8)
								next_q.sda_oe = (q.st == cbi_pkg::H_RXB) && more_rx;
							else
								next_q.sda_oe = (q.st == cbi_pkg::H_TXB) && !q.sh[7];
						end
						2'h1: next_q.scl_oe = 1'b0;
						2'h2: begin
							if (q.bitn == 4'h8)
								next_q.ackbit = ~q.sda_sy[1];
							else if (q.st == cbi_pkg::H_RXB)
								next_q.sh = {q.sh[6:0], q.sda_sy[1]};
						end
						2'h3: begin
							next_q.scl_oe = 1'b1;
							next_q.bitn   = q.bitn + 4'h1;
							if (q.st == cbi_pkg::H_TXB && q.bitn != 4'h8)
								next_q.sh = {q.sh[6:0], 1'b0};
							if (q.bitn == 4'h8) begin
								next_q.bitn = 4'h0;
								if (q.st == cbi_pkg::H_RXB) begin
									next_q.buffer[q.nb[2:0]] = q.sh;
									next_q.nb = q.nb + 4'h1;
									if (!more_rx)
										next_q.st = cbi_pkg::H_STOP;
								end else if (!q.ackbit) begin
									next_q.nack = 1'b1;
									next_q.st   = cbi_pkg::H_STOP;
								end else if (q.rdp) begin
									next_q.st = cbi_pkg::H_RXB;
									next_q.nb = 4'h0;
								end else if (q.seq == 2'h0) begin
									next_q.seq = 2'h1;
									next_q.sh  = q.ptr[15:8];
								end else if (q.seq == 2'h1) begin
									next_q.seq = 2'h2;
									next_q.sh  = q.ptr[7:0];
								end else if (q.rd_op) begin
									next_q.rdp = 1'b1;
									next_q.st  = cbi_pkg::H_START;
								end else if (q.nb < q.len) begin
									next_q.sh = q.buffer[q.nb[2:0]];
									next_q.nb = q.nb + 4'h1;
								end else begin
									next_q.st = cbi_pkg::H_STOP;
								end
							end
						end
					endcase
				end
				cbi_pkg::H_STOP: begin
					unique case (q.ph)
						2'h0: next_q.sda_oe = 1'b1;
						2'h1: next_q.scl_oe = 1'b0;
						2'h2: next_q.sda_oe = 1'b0;
						2'h3: begin
							next_q.st   = cbi_pkg::H_IDLE;
							next_q.busy = 1'b0;
						end
					endcase
				end
				default: next_q.st = cbi_pkg::H_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			q    <= '0;
			q.st <= cbi_pkg::H_IDLE;
			q.ph <= 2'h0;
		end else begin
			q <= next_q;
		end
	end

	assign link.scl_host_o  = 1'b0;
	assign link.scl_host_oe = q.scl_oe;
	assign link.sda_host_o  = 1'b0;
	assign link.sda_host_oe = q.sda_oe;
	assign rdata            = q.rdata;
endmodule : cbi_host

//--- cbi_link_if.sv
`timescale 1ns/1ps
interface cbi_link_if;
	logic scl_host_o;
	logic scl_host_oe;
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic scl;
	logic sda;

	// pull-up: a line is low only while some driver pulls it low
	assign scl = ~(scl_host_oe & ~scl_host_o);
	assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

	modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
	modport host (input scl, input sda, output scl_host_o, output scl_host_oe,
		output sda_host_o, output sda_host_oe);
endinterface : cbi_link_if

//--- cbi_link_props.sv
`timescale 1ns/1ps
module cbi_link_props (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// line drivers
	input wire logic scl_host_o,
	input wire logic scl_host_oe,
	input wire logic sda_host_o,
	input wire logic sda_host_oe,
	input wire logic sda_dev_o,
	input wire logic sda_dev_oe,
	// resolved lines
	input wire logic scl,
	input wire logic sda
);
	localparam int T_LOW_MIN  = 325;
	localparam int T_HIGH_MIN = 150;
	// slowest legal clock, so no low phase can reach a full period
	localparam int T_LOW_MAX  = 25000;

	logic [15:0] low_cnt;
	logic [15:0] high_cnt;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// saturating counters of the current line phase
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			low_cnt  <= 16'h0000;
			high_cnt <= 16'h0000;
		end else begin
			low_cnt  <= scl ? 16'h0000 : ((low_cnt == 16'hFFFF) ? low_cnt : low_cnt + 16'h0001);
			high_cnt <= !scl ? 16'h0000 : ((high_cnt == 16'hFFFF) ? high_cnt : high_cnt + 16'h0001);
		end
	end

	AST_SCL_OPEN_DRAIN: assert property (scl_host_oe |-> !scl_host_o && !scl)
		else $error("clock line driven high or not pulled low");
	AST_SDA_HOST_OPEN_DRAIN: assert property (sda_host_oe |-> !sda_host_o && !sda)
		else $error("host data driver not open drain");
	AST_SDA_DEV_OPEN_DRAIN: assert property (sda_dev_oe |-> !sda_dev_o && !sda)
		else $error("device data driver not open drain");
	AST_DEV_STILL_SCL_HIGH: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
		else $error("device changed data while clock high");
	AST_DEV_ANSWER_DELAY: assert property ($changed(sda_dev_oe) |->
		low_cnt >= 16'h0001 && low_cnt <= 16'h0008)
		else $error("device data change not just after clock fall");
	AST_SCL_LOW_MIN: assert property ($rose(scl) |-> low_cnt >= T_LOW_MIN)
		else $error("clock low phase too short");
	AST_SCL_HIGH_MIN: assert property ($fell(scl) |-> high_cnt >= T_HIGH_MIN)
		else $error("clock high phase too short");
	AST_SCL_LOW_MAX: assert property (!scl |-> low_cnt < T_LOW_MAX)
		else $error("clock low phase too long");

	cover property ($rose(sda_dev_oe));
	cover property ($fell(sda) && scl);
	cover property ($rose(sda) && scl);
endmodule : cbi_link_props

//--- cbi_pkg.sv
package cbi_pkg;
	// timing
	localparam int unsigned CLK_PERIOD_NS      = 4;
	localparam int unsigned POR_TIME_MS        = 10;
	localparam int unsigned POR_CYCLES         = POR_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned NVM_CYCLES         = 64;
	// rate whose half-period low phase of 332 cycles still meets the 325-cycle minimum low time
	localparam int unsigned SCL_FREQ_KHZ       = 375;
	localparam int unsigned SCL_QUARTER_CYCLES = 1000000 / (CLK_PERIOD_NS * SCL_FREQ_KHZ * 4);

	// device register map, byte pointers
	localparam int          NREG         = 8;
	localparam logic [15:0] REG_ADDR_SEL = 16'h0000;
	localparam logic [15:0] REG_OUT_EN   = 16'h0001;
	localparam logic [15:0] REG_DRIVE    = 16'h0002;
	localparam logic [15:0] REG_PAIR     = 16'h0003;
	localparam logic [15:0] REG_NVM_CMD  = 16'h0072;
	localparam int          ADDR_SEL_BIT = 0;
	localparam int          BURN_BIT     = 3;
	localparam int          RESTORE_BIT  = 0;
	localparam int          BUSY_BIT     = 7;
	localparam int          PAIR_SE_LSB  = 0;
	localparam int          PAIR_INV_LSB = 2;

	// 7-bit slave addresses (0xD4 and 0xD0 in 8-bit form)
	localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h6A;
	localparam logic [6:0] DEV_ADDR_ALT     = 7'h68;

	// driver standards, two bits per output in the drive register
	localparam logic [1:0] DRV_LVCMOS = 2'h0;
	localparam logic [1:0] DRV_LVPECL = 2'h1;
	localparam logic [1:0] DRV_HCSL   = 2'h2;
	localparam logic [1:0] DRV_LVDS   = 2'h3;

	// factory contents of the four banks: both outputs enabled, LVCMOS
	localparam logic [3:0][NREG-1:0][7:0] OTP_FACTORY = {4{64'h0000_0000_0000_0300}};

	// controller registers
	localparam logic [3:0] HREG_DEV   = 4'h0;
	localparam logic [3:0] HREG_PTRH  = 4'h1;
	localparam logic [3:0] HREG_PTRL  = 4'h2;
	localparam logic [3:0] HREG_LEN   = 4'h3;
	localparam logic [3:0] HREG_CTRL  = 4'h4;
	localparam logic [3:0] HREG_STAT  = 4'h5;
	localparam logic [3:0] HREG_DATA  = 4'h8;
	localparam int         CTRL_START = 0;
	localparam int         CTRL_READ  = 1;
	localparam int         STAT_BUSY  = 0;
	localparam int         STAT_NACK  = 1;

	typedef enum logic [4:0] {
		D_IDLE = 5'h01,
		D_RX   = 5'h02,
		D_ACK  = 5'h04,
		D_TX   = 5'h08,
		D_MACK = 5'h10
	} cbi_dst_t;

	typedef enum logic [4:0] {
		H_IDLE  = 5'h01,
		H_START = 5'h02,
		H_TXB   = 5'h04,
		H_RXB   = 5'h08,
		H_STOP  = 5'h10
	} cbi_hst_t;
endpackage : cbi_pkg

//--- clock_buffer_config_i2c_port_test.sv
`timescale 1ns/1ps
`define CHECK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
	$display("Error at %0t ns: got %h expected %h", $time, (a), (b)); end end
module clock_buffer_config_i2c_port_test;
	localparam int unsigned POR_SIM = 20;
	logic       ref_clk;
	logic       reset_n;
	logic [1:0] cfg_select;
	logic       src_clk;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic [1:0] clock_out_true;
	logic [1:0] clock_out_complement;
	logic [3:0] drive_type;
	logic       config_ready;
	logic [7:0] wbuf [3];
	logic [7:0] st;
	logic [7:0] d;
	int         fails;
	int         n_compared;
	int         seed;

	cbi_link_if cbi_link_if_i ();
	cbi_device #(.POR_CYCLES(POR_SIM)) cbi_device_i (.ref_clk(ref_clk), .reset_n(reset_n),
		.link(cbi_link_if_i), .cfg_select(cfg_select), .src_clk(src_clk),
		.clock_out_true(clock_out_true), .clock_out_complement(clock_out_complement),
		.drive_type(drive_type), .config_ready(config_ready));
	cbi_host cbi_host_i (.ref_clk(ref_clk), .reset_n(reset_n), .link(cbi_link_if_i),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	cbi_link_props cbi_link_props_i (.ref_clk(ref_clk), .reset_n(reset_n),
		.scl_host_o(cbi_link_if_i.scl_host_o), .scl_host_oe(cbi_link_if_i.scl_host_oe),
		.sda_host_o(cbi_link_if_i.sda_host_o), .sda_host_oe(cbi_link_if_i.sda_host_oe),
		.sda_dev_o(cbi_link_if_i.sda_dev_o), .sda_dev_oe(cbi_link_if_i.sda_dev_oe),
		.scl(cbi_link_if_i.scl), .sda(cbi_link_if_i.sda));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	function automatic logic [3:0] exp_clk(input logic [7:0] en, input logic [7:0] pr,
		input logic s);
		logic [3:0] r;
		for (int k = 0; k < 2; k++) begin
			r[k] = en[k] & s;
			r[k+2] = en[k] & (pr[k] ? (s ^ pr[k+2]) : ~s);
		end
		return r;
	endfunction : exp_clk

	task automatic hw(input logic [3:0] a, input logic [7:0] v);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		rd <= 1'b0;
		@(posedge ref_clk);
	endtask : hw

	// read data stand only in the cycle after the strobe
	task automatic hr(input logic [3:0] a, output logic [7:0] v);
		addr <= a;
		rd <= 1'b1;
		wr <= 1'b0;
		@(posedge ref_clk);
		rd <= 1'b0;
		@(negedge ref_clk);
		v = rdata;
		@(posedge ref_clk);
	endtask : hr

	task automatic xfer(input logic [6:0] dev, input logic [7:0] ptr, input int len,
		input logic read);
		hw(cbi_pkg::HREG_DEV, {1'b0, dev});
		hw(cbi_pkg::HREG_PTRH, 8'h00);
		hw(cbi_pkg::HREG_PTRL, ptr);
		hw(cbi_pkg::HREG_LEN, 8'(len));
		for (int i = 0; i < len; i++) begin
			// a read preloads the inverse so stale buffer bytes cannot pass
			hw(4'h8 + 4'(i), read ? ~wbuf[i] : wbuf[i]);
		end
		hw(cbi_pkg::HREG_CTRL, {6'h00, read, 1'b1});
		wr <= 1'b0;
		do begin
			repeat (64) @(posedge ref_clk);
			hr(cbi_pkg::HREG_STAT, st);
		end while (st[cbi_pkg::STAT_BUSY]);
	endtask : xfer

	task automatic chk_cfg(input logic [7:0] en, input logic [7:0] drv, input logic [7:0] pr);
		for (int s = 0; s < 2; s++) begin
			src_clk <= s[0];
			repeat (6) @(posedge ref_clk);
			`CHECK({clock_out_complement, clock_out_true}, exp_clk(en, pr, s[0]))
		end
		`CHECK(drive_type, drv[3:0])
	endtask : chk_cfg

	task automatic wait_ready;
		int n;
		n = 0;
		while (config_ready !== 1'b1 && n < POR_SIM + cbi_pkg::NVM_CYCLES + 16) begin
			@(posedge ref_clk);
			n++;
		end
		`CHECK(config_ready, 1'b1)
	endtask : wait_ready

	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report

	initial begin
		#1000000;
		fails++;
		final_report();
	end

	initial begin
		seed = 28;
		fails = 0;
		n_compared = 0;
		reset_n = 1'b0;
		cfg_select = 2'($random(seed));
		src_clk = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		src_clk <= 1'b1;
		repeat (4) @(posedge ref_clk);
		`CHECK({config_ready, clock_out_complement, clock_out_true}, 5'h00)
		wait_ready();
		chk_cfg(8'h03, 8'h00, 8'h00);
		$display("test power_up done");
		// output 1 off, pair 0 single-ended with inverted complement
		wbuf = '{8'h01, {4'h0, cbi_pkg::DRV_HCSL, cbi_pkg::DRV_LVDS}, 8'h05};
		xfer(cbi_pkg::DEV_ADDR_DEFAULT, cbi_pkg::REG_OUT_EN[7:0], 3, 1'b0);
		`CHECK(st[cbi_pkg::STAT_NACK], 1'b0)
		chk_cfg(wbuf[0], wbuf[1], wbuf[2]);
		$display("test corner_write done");
		wbuf = '{8'($random(seed)) & 8'h03, {4'h0, cbi_pkg::DRV_LVCMOS, cbi_pkg::DRV_LVPECL},
			8'($random(seed)) & 8'h0F};
		fork
			xfer(cbi_pkg::DEV_ADDR_DEFAULT, cbi_pkg::REG_OUT_EN[7:0], 3, 1'b0);
			begin
				// last data byte is in flight here, nothing may be committed yet
				repeat (200 * cbi_pkg::SCL_QUARTER_CYCLES) @(posedge ref_clk);
				`CHECK(drive_type, {cbi_pkg::DRV_HCSL, cbi_pkg::DRV_LVDS})
			end
		join
		chk_cfg(wbuf[0], wbuf[1], wbuf[2]);
		$display("test random_write done");
		xfer(cbi_pkg::DEV_ADDR_DEFAULT, cbi_pkg::REG_OUT_EN[7:0], 3, 1'b1);
		for (int i = 0; i < 3; i++) begin
			hr(4'h8 + 4'(i), d);
			`CHECK(d, wbuf[i])
		end
		$display("test read_back done");
		xfer(cbi_pkg::DEV_ADDR_ALT, cbi_pkg::REG_OUT_EN[7:0], 1, 1'b0);
		`CHECK(st[cbi_pkg::STAT_NACK], 1'b1)
		$display("test other_address done");
		reset_n <= 1'b0;
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		wait_ready();
		chk_cfg(8'h03, 8'h00, 8'h00);
		$display("test second_reset done");
		final_report();
	end
endmodule : clock_buffer_config_i2c_port_test
